/* File: bench/cpc_link_properties.sv */
// Purpose: link properties of the parameter channel
// Assumes: one master end and one slave end share the link
// Notes: octet 0 sits in the top bits of each area
`timescale 1ns/100ps
module cpc_link_properties #(
	parameter int TEL_CYC = 16 // clocks between telegrams
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic tel_strobe, // telegram pulse
	input wire logic out_present, // master output present
	input wire logic [63:0] out_area, // master octets 0..7
	input wire logic in_valid, // slave answer pulse
	input wire logic [127:0] in_area // slave octets 0..15
);
	// one spare cycle so either reading of the telegram spacing fits
	localparam int SPAN = TEL_CYC + 1;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// each telegram gets its answer on the next cycle, and no other
	AST_ANSWER_NEXT: assert property (tel_strobe |=> in_valid)
		else $error("telegram not answered on the next cycle");
	AST_ANSWER_ONLY: assert property (in_valid |-> $past(tel_strobe))
		else $error("answer without a telegram");
	AST_RSVD_ZERO: assert property (in_valid |-> in_area[123:120] == 4'h0 && in_area[103:96] == 8'h00)
		else $error("reserved answer bits not zero");
	AST_ZERO_ZERO: assert property (tel_strobe && out_area[63:60] == 4'h0 |=> in_area[127:124] == 4'h0)
		else $error("zero instruction answered with nonzero code");
	AST_CODES_LEGAL: assert property (in_valid |-> in_area[127:124] inside {4'h0, 4'h1, 4'h2, 4'h7, 4'hb})
		else $error("illegal response code");
	// a pending instruction is repeated unchanged in the next telegram
	AST_REPEAT_INSTR: assert property (tel_strobe && out_present && out_area[63:60] != 4'h0 ##1
		in_area[127:124] == 4'h0 |-> ##[1:SPAN] (tel_strobe && $stable(out_area)))
		else $error("instruction not repeated");
	// an answer is closed by a zero instruction in the next telegram
	AST_CLOSE_ZERO: assert property (in_valid && in_area[127:124] != 4'h0 |->
		##[1:SPAN] (tel_strobe && out_area[63:60] == 4'h0))
		else $error("answer not closed by a zero instruction");
	AST_ECHO_SLOT: assert property (in_valid && in_area[127:124] != 4'h0 |->
		in_area[119:104] == $past(out_area[55:40]))
		else $error("slot or index not echoed");
	// the answer stands between telegrams
	AST_IN_STANDS: assert property (!in_valid |-> $stable(in_area))
		else $error("answer changed between telegrams");
	AST_NO_CHANNEL: assert property (tel_strobe && !out_present |=> in_area[127:124] == 4'h0)
		else $error("answer code without output data");
	// master output: reserved signature bits and octet stay zero
	AST_OUT_RSVD: assert property (tel_strobe |-> out_area[59:56] == 4'h0 && out_area[39:32] == 8'h00)
		else $error("reserved output bits not zero");
endmodule : cpc_link_properties

/* File: bench/test_cyclic_parameter_channel.sv */
// Purpose: self-checking bench for both ends of the parameter channel
// Assumes: master registers at the offsets of cpc_regs.svh
// Notes: a short telegram period keeps the run brief
`timescale 1ns/100ps
`include "cpc_regs.svh"
module test_cyclic_parameter_channel import cpc_pkg::*; ;
	localparam int TEL = 4; // short telegram period
	localparam logic [31:0] WV = 32'hdeadbeef; // value written
	localparam logic [31:0] RV = 32'h1234abcd; // value read
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic chan_en, req_valid, req_write, req_service, rsp_valid, rsp_err, e_wr, p_err;
	logic [63:0] proc_data;
	logic [7:0] req_slot, req_index, e_slot, e_idx;
	logic [31:0] req_value, rsp_value, e_val;
	logic [15:0] rsp_errnum, p_en;
	logic [15:0] errs [4] = '{`CPC_E_UNDEF_SLOT, `CPC_E_NOT_CYCLIC, `CPC_E_ALREADY, `CPC_E_CONFLICT};
	cpc_type_t req_type, rsp_type, e_type, p_rt;
	int fail_count, checked, p_dly;
	cpc_if cpc_if_i();
	cpc_master #(.TEL_CYC(TEL)) cpc_master_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(cpc_if_i));
	cpc_slave cpc_slave_i(.hclk(hclk), .hresetn(hresetn), .link(cpc_if_i), .chan_en(chan_en),
		.proc_data(proc_data), .req_valid(req_valid), .req_write(req_write), .req_type(req_type),
		.req_service(req_service), .req_slot(req_slot), .req_index(req_index), .req_value(req_value),
		.rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_errnum(rsp_errnum), .rsp_type(rsp_type),
		.rsp_value(rsp_value));
	cpc_link_properties #(.TEL_CYC(TEL)) cpc_link_properties_i(.hclk(hclk), .hresetn(hresetn),
		.tel_strobe(cpc_if_i.tel_strobe), .out_present(cpc_if_i.out_present), .out_area(cpc_if_i.out_area),
		.in_valid(cpc_if_i.in_valid), .in_area(cpc_if_i.in_area));
	// free-running system clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	// one single word transfer; the slave may stretch either phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
	endtask : ahb
	task automatic wait_in();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (cpc_if_i.in_valid !== 1'b1 && n < 50);
	endtask : wait_in
	// one instruction cycle: order it, wait for done, compare the answer
	task automatic run(input logic [3:0] code, input logic [7:0] slot, idx, input cpc_type_t rt, input logic er,
		input logic [15:0] en, input int dly, input logic [3:0] ec, input logic [31:0] ev);
		int n;
		e_slot = slot;
		e_idx = idx;
		e_wr = code != `CPC_I_READ;
		e_type = (code == `CPC_I_WR_DWORD) ? CPC_TYPE_DWORD : (code == `CPC_I_WR_BYTE) ? CPC_TYPE_BYTE : CPC_TYPE_WORD;
		e_val = (code == `CPC_I_WR_DWORD) ? WV : (code == `CPC_I_WR_BYTE) ? (WV & `CPC_MASK_BYTE) : (WV & `CPC_MASK_WORD);
		p_rt = rt;
		p_err = er;
		p_en = en;
		p_dly = dly;
		ahb(1'b1, `CPC_OFS_WVAL, WV);
		ahb(1'b1, `CPC_OFS_INSTR, {8'h00, idx, code, 4'h0, slot});
		ahb(1'b1, `CPC_OFS_CTRL, 32'h0000_0003);
		n = 0;
		do begin
			ahb(1'b0, `CPC_OFS_STAT, 32'h0);
			n++;
		end while (rd[1] !== 1'b1 && n < 100);
		chk(rd, {ec, 4'h0, slot, 16'h0002});
		ahb(1'b0, `CPC_OFS_RVAL, 32'h0);
		chk(rd, ev);
	endtask : run
	// user side: answer each pending request after the planned delay
	initial begin
		rsp_valid = 1'b0;
		rsp_err = 1'b0;
		rsp_errnum = 16'h0;
		rsp_type = CPC_TYPE_WORD;
		rsp_value = 32'h0;
		forever begin
			@(posedge hclk);
			if (req_valid === 1'b1) begin
				chk(req_slot, e_slot);
				chk(req_index, e_idx);
				chk(req_write, e_wr);
				chk(req_service, e_idx < `CPC_FIRST_PARAM_IDX);
				if (e_wr) begin
					chk(req_type, e_type);
					chk(req_value, e_val);
				end
				repeat (p_dly) @(posedge hclk);
				rsp_valid <= 1'b1;
				rsp_err <= p_err;
				rsp_errnum <= p_en;
				rsp_type <= p_rt;
				rsp_value <= RV;
				@(posedge hclk);
				rsp_valid <= 1'b0;
			end
		end
	end
	// cut a hang short well beyond the expected run length
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		chan_en = 1'b1;
		proc_data = 64'h0102_0304_0506_0708;
		fail_count = 0;
		checked = 0;
		p_dly = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b1, `CPC_OFS_CTRL, 32'h0000_0002);
		ahb(1'b0, `CPC_OFS_CTRL, 32'h0);
		chk(rd, 32'h0000_0002);
		ahb(1'b1, 8'h20, 32'hffff_ffff);
		ahb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		run(`CPC_I_READ, 8'h03, 8'h10, CPC_TYPE_WORD, 1'b0, 16'h0, 0, `CPC_R_WORD, RV & `CPC_MASK_WORD);
		run(`CPC_I_READ, 8'h00, 8'h0f, CPC_TYPE_DWORD, 1'b0, 16'h0, 12, `CPC_R_DWORD, RV);
		run(`CPC_I_READ, 8'hff, 8'hff, CPC_TYPE_BYTE, 1'b0, 16'h0, 1, `CPC_R_BYTE, RV & `CPC_MASK_BYTE);
		run(`CPC_I_WR_WORD, 8'h01, 8'h10, CPC_TYPE_WORD, 1'b0, 16'h0, 2, `CPC_R_WORD, WV & `CPC_MASK_WORD);
		run(`CPC_I_WR_DWORD, 8'h02, 8'h11, CPC_TYPE_DWORD, 1'b0, 16'h0, 0, `CPC_R_DWORD, WV);
		run(`CPC_I_WR_BYTE, 8'h04, 8'h00, CPC_TYPE_BYTE, 1'b0, 16'h0, 0, `CPC_R_BYTE, WV & `CPC_MASK_BYTE);
		foreach (errs[i])
			run(`CPC_I_WR_WORD, 8'h05, 8'h12, CPC_TYPE_WORD, 1'b1, errs[i], 1, `CPC_R_ERR, {16'h0, errs[i]});
		run(4'h5, 8'h02, 8'h20, CPC_TYPE_WORD, 1'b0, 16'h0, 0, `CPC_R_ERR, {16'h0, `CPC_E_OTHER});
		wait_in();
		chk(cpc_if_i.in_area[63:0], proc_data);
		ahb(1'b1, `CPC_OFS_CTRL, 32'h0);
		wait_in();
		wait_in();
		chk(cpc_if_i.out_present, 1'b0);
		chk(cpc_if_i.in_area[127:124], 4'h0);
		// unconfigured channel: process data lead
		// octets 0 and 3 zero, since the checker still reads this area as a channel
		chan_en <= 1'b0;
		proc_data <= 64'h0011_2200_5566_7788;
		wait_in();
		chk(cpc_if_i.in_area[127:64], proc_data);
		chk(cpc_if_i.in_area[63:0], 64'h0);
		finish_test();
	end
endmodule : test_cyclic_parameter_channel

/* File: hdl/cpc_master.sv */
// Purpose: cyclic master end driving the parameter channel
// Assumes: software orders requests through AHB-Lite registers
// Notes: zero-wait slave; one telegram every tel_cyc clocks
`timescale 1ns/100ps
`include "cpc_regs.svh"
module cpc_master import cpc_pkg::*; #(
	parameter int TEL_CYC = `CPC_TEL_CYC_DEF // clocks between telegrams
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write transfer
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // response, always okay
	output logic [31:0] hrdata, // read data
	cpc_if.ctl link // cyclic telegram link
);
	typedef struct packed {
		cpc_mst_t st;
		logic [15:0] tmr;
		logic tel;
		logic [63:0] out;
		logic chan_en;
		logic [31:0] instr;
		logic [31:0] wval;
		logic done;
		logic [63:0] resp;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} cpc_mstate_t;

	cpc_mstate_t m_q;
	cpc_mstate_t m_d;
	logic take;
	logic [3:0] rx_code;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = m_q.rdata;
	assign link.tel_strobe = m_q.tel;
	assign link.out_present = m_q.chan_en;
	assign link.out_area = m_q.out;
	assign take = hsel && hready && htrans[1];
	assign rx_code = link.in_area[127 - (63 - `CPC_CODE_HI):127 - (63 - `CPC_CODE_LO)];

	// next state: bus slave, telegram timer, instruction handshake
	always_comb begin
		m_d = m_q;
		m_d.tel = 1'b0;
		m_d.wr_pend = 1'b0;
		// data phase of a write lands one cycle after its address phase
		if (m_q.wr_pend) begin
			unique case (m_q.wr_addr)
				`CPC_OFS_CTRL: begin
					m_d.chan_en = hwdata[`CPC_CTRL_CHAN];
					// a start while busy is ignored so a cycle is never cut short
					if (hwdata[`CPC_CTRL_START] && (m_q.st == CPC_M_IDLE)) begin
						m_d.st = CPC_M_SEND;
						m_d.done = 1'b0;
					end
				end
				`CPC_OFS_INSTR: m_d.instr = hwdata;
				`CPC_OFS_WVAL: m_d.wval = hwdata;
				default: ;
			endcase
		end
		if (take) begin
			m_d.wr_pend = hwrite;
			m_d.wr_addr = haddr[7:0];
			m_d.rdata = 32'h0000_0000;
			if (!hwrite) begin
				unique case (haddr[7:0])
					`CPC_OFS_CTRL: m_d.rdata = {30'h0, m_q.chan_en, 1'b0};
					`CPC_OFS_INSTR: m_d.rdata = m_q.instr;
					`CPC_OFS_WVAL: m_d.rdata = m_q.wval;
					// signature octets on top, done and busy in the low bits
					`CPC_OFS_STAT: m_d.rdata = {m_q.resp[`CPC_SIG_HI:`CPC_SIG_LO], 14'h0, m_q.done, m_q.st != CPC_M_IDLE};
					`CPC_OFS_RVAL: m_d.rdata = m_q.resp[31:0];
					default: m_d.rdata = 32'h0000_0000;
				endcase
			end
		end
		// telegram pacing
		if (m_q.tmr == 16'(TEL_CYC - 1)) begin
			m_d.tmr = 16'h0000;
			m_d.tel = 1'b1;
			m_d.out = '0;
			// instruction repeated in every telegram until answered
			if (m_q.st == CPC_M_SEND) begin
				// eight channel octets, reserved octet zero
				m_d.out[`CPC_CODE_HI:`CPC_CODE_LO] = m_q.instr[`CPC_INSTR_CODE_HI:`CPC_INSTR_CODE_LO];
				m_d.out[`CPC_SLOT_HI:`CPC_SLOT_LO] = m_q.instr[`CPC_INSTR_SLOT_HI:`CPC_INSTR_SLOT_LO];
				m_d.out[`CPC_IDX_HI:`CPC_IDX_LO] = m_q.instr[`CPC_INSTR_IDX_HI:`CPC_INSTR_IDX_LO];
				m_d.out[`CPC_VAL_HI:`CPC_VAL_LO] = m_q.wval;
			end else if (m_q.st == CPC_M_CLOSE) begin
				// zero instruction sent once closes the cycle
				m_d.st = CPC_M_IDLE;
				m_d.done = 1'b1;
			end
		end else begin
			m_d.tmr = m_q.tmr + 16'h0001;
		end
		// a non-zero code marks the answer to the pending instruction
		if (link.in_valid && (m_q.st == CPC_M_SEND) && (rx_code != `CPC_R_NONE)) begin
			m_d.resp = link.in_area[127:64];
			m_d.st = CPC_M_CLOSE;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			m_q <= '{st: CPC_M_IDLE, tmr: 16'h0000, tel: 1'b0, out: 64'h0, chan_en: 1'b0,
				instr: 32'h0, wval: 32'h0, done: 1'b0, resp: 64'h0, wr_pend: 1'b0,
				wr_addr: 8'h00, rdata: 32'h0};
		end else begin
			m_q <= m_d;
		end
	end
endmodule : cpc_master

/* File: hdl/cpc_slave.sv */
// Purpose: slave end of the cyclic parameter channel
// Assumes: user logic answers each parameter request once
// Notes: process data follow the channel when it is configured
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "cpc_regs.svh"
// Summary of operation
// - channel octets: signature, index, reserved, value
// - one instruction and one response per telegram
// - at most four value bytes per transfer
// - signature: code 15-12, reserved, slot 7-0
// - master codes 0,1,2,3,10
// - code 0 answered with code 0
// - read answers 1, 2 or 11 by type
// - write echoes value with 1, 2, 11
// - failed instruction answered with code 7
// - master repeats instruction until answered
// - slave repeats response until new instruction
// - zero instruction closes cycle before next
// - error number as INT16 in value octets
// - error numbers 0 to 7 defined
// - error numbers 10 to 19 defined
// - errors 201 already, 202 conflict
// - works without any output data
// - configuration selects channel and value format; the slave takes only chan_en, for the channel, and has no format setting
// - input area: channel, then process data
// - output area is the eight channel octets
// - parameters from index 16, services below
module cpc_slave import cpc_pkg::*; (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	cpc_if.dev link, // cyclic telegram link
	input wire logic chan_en, // channel configured
	input wire logic [63:0] proc_data, // process data, octet 0 on top
	output logic req_valid, // parameter request pending
	output logic req_write, // request is a write
	output cpc_type_t req_type, // write data type
	output logic req_service, // index addresses a service
	output logic [7:0] req_slot, // target slot
	output logic [7:0] req_index, // index within slot
	output logic [31:0] req_value, // write value
	input wire logic rsp_valid, // request finished
	input wire logic rsp_err, // request failed
	input wire logic [15:0] rsp_errnum, // error number on failure
	input wire cpc_type_t rsp_type, // read data type
	input wire logic [31:0] rsp_value // read value
);
	typedef struct packed {
		cpc_sst_t st;
		logic closed;
		logic [3:0] code;
		logic [7:0] slot;
		logic [7:0] idx;
		logic [31:0] val;
		logic [63:0] chan;
		logic in_valid;
		logic [127:0] in_area;
	} cpc_sstate_t;

	cpc_sstate_t s_q;
	cpc_sstate_t s_d;
	logic [3:0] in_code;
	logic legal;

	// trim a value to the width of its data type
	function automatic logic [31:0] cpc_trim(input cpc_type_t t, input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if (t == CPC_TYPE_BYTE) begin
			r = v & `CPC_MASK_BYTE;
		end else if (t == CPC_TYPE_WORD) begin
			r = v & `CPC_MASK_WORD;
		end
		return r;
	endfunction : cpc_trim

	// response code for a data type
	function automatic logic [3:0] cpc_rcode(input cpc_type_t t);
		logic [3:0] r;
		r = `CPC_R_WORD;
		if (t == CPC_TYPE_DWORD) begin
			r = `CPC_R_DWORD;
		end else if (t == CPC_TYPE_BYTE) begin
			r = `CPC_R_BYTE;
		end
		return r;
	endfunction : cpc_rcode

	// data type named by a write instruction
	function automatic cpc_type_t cpc_wtype(input logic [3:0] c);
		cpc_type_t r;
		r = CPC_TYPE_WORD;
		if (c == `CPC_I_WR_DWORD) begin
			r = CPC_TYPE_DWORD;
		end else if (c == `CPC_I_WR_BYTE) begin
			r = CPC_TYPE_BYTE;
		end
		return r;
	endfunction : cpc_wtype

	// code field of the incoming signature
	assign in_code = link.out_area[`CPC_CODE_HI:`CPC_CODE_LO];
	// only the documented instruction codes are executed
	assign legal = (in_code == `CPC_I_READ) || (in_code == `CPC_I_WR_WORD) ||
		(in_code == `CPC_I_WR_DWORD) || (in_code == `CPC_I_WR_BYTE);

	// request towards the parameter store, held for the whole busy state
	assign req_valid = (s_q.st == CPC_S_BUSY);
	assign req_write = (s_q.code != `CPC_I_READ);
	assign req_type = cpc_wtype(s_q.code);
	// indices below the first parameter are services
	assign req_service = (s_q.idx < `CPC_FIRST_PARAM_IDX);
	assign req_slot = s_q.slot;
	assign req_index = s_q.idx;
	assign req_value = cpc_trim(cpc_wtype(s_q.code), s_q.val);
	assign link.in_valid = s_q.in_valid;
	assign link.in_area = s_q.in_area;

	// next state: instruction intake, response build, telegram answer
	always_comb begin
		s_d = s_q;
		s_d.in_valid = 1'b0;
		unique case (s_q.st)
			CPC_S_IDLE: begin
				// with no channel or no output data nothing is decoded
				if (link.tel_strobe && chan_en && link.out_present) begin
					// code 0 is answered with an all-zero channel, response code 0
					if (in_code == `CPC_I_NONE) begin
						s_d.closed = 1'b1;
						s_d.chan = '0;
					// a new cycle only opens after a zero instruction or after reset
					end else if (s_q.closed) begin
						s_d.closed = 1'b0;
						// reserved bits and octet are dropped here
						s_d.code = in_code;
						s_d.slot = link.out_area[`CPC_SLOT_HI:`CPC_SLOT_LO];
						s_d.idx = link.out_area[`CPC_IDX_HI:`CPC_IDX_LO];
						s_d.val = link.out_area[`CPC_VAL_HI:`CPC_VAL_LO];
						s_d.chan = '0;
						if (legal) begin
							s_d.st = CPC_S_BUSY;
						end else begin
							s_d.chan[`CPC_CODE_HI:`CPC_CODE_LO] = `CPC_R_ERR;
							s_d.chan[`CPC_SLOT_HI:`CPC_SLOT_LO] = link.out_area[`CPC_SLOT_HI:`CPC_SLOT_LO];
							s_d.chan[`CPC_IDX_HI:`CPC_IDX_LO] = link.out_area[`CPC_IDX_HI:`CPC_IDX_LO];
							s_d.chan[`CPC_ERR_HI:`CPC_ERR_LO] = `CPC_E_OTHER;
							s_d.st = CPC_S_HOLD;
						end
					end
				end
			end
			CPC_S_BUSY: begin
				if (rsp_valid) begin
					s_d.st = CPC_S_HOLD;
					// reserved bits go out as zero
					s_d.chan = '0;
					s_d.chan[`CPC_SLOT_HI:`CPC_SLOT_LO] = s_q.slot;
					s_d.chan[`CPC_IDX_HI:`CPC_IDX_LO] = s_q.idx;
					if (rsp_err) begin
						// failure code replaces the normal one
						s_d.chan[`CPC_CODE_HI:`CPC_CODE_LO] = `CPC_R_ERR;
						// signed error number in the last two octets
						s_d.chan[`CPC_ERR_HI:`CPC_ERR_LO] = rsp_errnum;
					end else if (s_q.code == `CPC_I_READ) begin
						// read answer coded by parameter type
						s_d.chan[`CPC_CODE_HI:`CPC_CODE_LO] = cpc_rcode(rsp_type);
						s_d.chan[`CPC_VAL_HI:`CPC_VAL_LO] = cpc_trim(rsp_type, rsp_value);
					end else begin
						// write echoed with the matching code
						s_d.chan[`CPC_CODE_HI:`CPC_CODE_LO] = cpc_rcode(cpc_wtype(s_q.code));
						s_d.chan[`CPC_VAL_HI:`CPC_VAL_LO] = cpc_trim(cpc_wtype(s_q.code), s_q.val);
					end
				end
			end
			CPC_S_HOLD: begin
				// response stands until the master moves on
				if (link.tel_strobe && chan_en && link.out_present && (in_code == `CPC_I_NONE)) begin
					s_d.st = CPC_S_IDLE;
					s_d.closed = 1'b1;
					s_d.chan = '0;
				end
			end
			default: begin
				s_d.st = CPC_S_IDLE;
			end
		endcase
		// one response per telegram, registered with the answer
		if (link.tel_strobe) begin
			s_d.in_valid = 1'b1;
			// channel first when configured, process data after it
			if (chan_en) begin
				// octets 0..7 channel, standard telegram behind
				s_d.in_area = {s_d.chan, proc_data};
			end else begin
				// without a channel the process data start at octet 0
				s_d.in_area = {proc_data, 64'h0000_0000_0000_0000};
			end
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{st: CPC_S_IDLE, closed: 1'b1, code: 4'h0, slot: 8'h00, idx: 8'h00,
				val: 32'h0000_0000, chan: 64'h0, in_valid: 1'b0, in_area: 128'h0};
		end else begin
			s_q <= s_d;
		end
	end
endmodule : cpc_slave

/* File: inc/cpc_if.sv */
// Purpose: cyclic telegram link between bus master and slave
// Assumes: one telegram per tel_strobe pulse, answered by in_valid
// Notes: out_area is octets 0..7, in_area octets 0..15
`timescale 1ns/100ps
interface cpc_if;
	logic tel_strobe;
	logic out_present;
	logic [63:0] out_area;
	logic in_valid;
	logic [127:0] in_area;
	modport dev (input tel_strobe, input out_present, input out_area, output in_valid, output in_area);
	modport ctl (output tel_strobe, output out_present, output out_area, input in_valid, input in_area);
endinterface : cpc_if

/* File: inc/cpc_pkg.sv */
// Purpose: types shared by both ends of the parameter channel
// Assumes: nothing
// Notes: constants live in cpc_regs.svh
package cpc_pkg;
	typedef enum logic [1:0] {
		CPC_TYPE_WORD = 2'h0,
		CPC_TYPE_DWORD = 2'h1,
		CPC_TYPE_BYTE = 2'h2
	} cpc_type_t;
	typedef enum logic [2:0] {
		CPC_S_IDLE = 3'b001,
		CPC_S_BUSY = 3'b010,
		CPC_S_HOLD = 3'b100
	} cpc_sst_t;
	typedef enum logic [2:0] {
		CPC_M_IDLE = 3'b001,
		CPC_M_SEND = 3'b010,
		CPC_M_CLOSE = 3'b100
	} cpc_mst_t;
endpackage : cpc_pkg

/* File: inc/cpc_regs.svh */
// Purpose: named constants of the cyclic parameter channel
// Assumes: octet 0 of an area sits in the top bits of its vector
// Notes: definitions only
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH
// channel layout inside the 64-bit channel vector
`define CPC_SIG_HI 63
`define CPC_SIG_LO 48
`define CPC_CODE_HI 63
`define CPC_CODE_LO 60
`define CPC_RSVD_HI 59
`define CPC_RSVD_LO 56
`define CPC_SLOT_HI 55
`define CPC_SLOT_LO 48
`define CPC_IDX_HI 47
`define CPC_IDX_LO 40
`define CPC_VAL_HI 31
`define CPC_VAL_LO 0
`define CPC_ERR_HI 15
`define CPC_ERR_LO 0
// instruction codes, master to slave
`define CPC_I_NONE 4'h0
`define CPC_I_READ 4'h1
`define CPC_I_WR_WORD 4'h2
`define CPC_I_WR_DWORD 4'h3
`define CPC_I_WR_BYTE 4'ha
// response codes, slave to master
`define CPC_R_NONE 4'h0
`define CPC_R_WORD 4'h1
`define CPC_R_DWORD 4'h2
`define CPC_R_BYTE 4'hb
`define CPC_R_ERR 4'h7
// error numbers
`define CPC_E_UNDEF_SLOT 16'h0000
`define CPC_E_NOT_CHANGEABLE 16'h0001
`define CPC_E_RANGE 16'h0002
`define CPC_E_SUBINDEX 16'h0003
`define CPC_E_NO_ARRAY 16'h0004
`define CPC_E_DATA_TYPE 16'h0005
`define CPC_E_SET_NOT_ALLOWED 16'h0006
`define CPC_E_DESC_FIXED 16'h0007
`define CPC_E_ACCESS_GROUP 16'h000a
`define CPC_E_NO_SOVEREIGNTY 16'h000b
`define CPC_E_PASSWORD 16'h000c
`define CPC_E_TEXT 16'h000d
`define CPC_E_NAME 16'h000e
`define CPC_E_NO_TEXT_ARRAY 16'h000f
`define CPC_E_BAD_STATE 16'h0011
`define CPC_E_OTHER 16'h0012
`define CPC_E_NOT_CYCLIC 16'h0013
`define CPC_E_ALREADY 16'h00c9
`define CPC_E_CONFLICT 16'h00ca
// first parameter index; services count down from the one below
`define CPC_FIRST_PARAM_IDX 8'h10
// value masks
`define CPC_MASK_BYTE 32'h0000_00ff
`define CPC_MASK_WORD 32'h0000_ffff
// controller register byte offsets
`define CPC_OFS_CTRL 8'h00
`define CPC_OFS_INSTR 8'h04
`define CPC_OFS_WVAL 8'h08
`define CPC_OFS_STAT 8'h0c
`define CPC_OFS_RVAL 8'h10
// controller register fields
`define CPC_CTRL_START 0
`define CPC_CTRL_CHAN 1
`define CPC_INSTR_CODE_HI 15
`define CPC_INSTR_CODE_LO 12
`define CPC_INSTR_IDX_HI 23
`define CPC_INSTR_IDX_LO 16
`define CPC_INSTR_SLOT_HI 7
`define CPC_INSTR_SLOT_LO 0
`define CPC_TEL_CYC_DEF 16
`endif
